// ===== hw/handler_out_pkg.sv
package handler_out_pkg;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int unsigned NUM_POINTS = 9;
  localparam logic [8:0] FAIL_LINES_RST = 9'h1ff;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic [1:0] SYNC_RST = 2'h0;

  // comparison mode that decides the pin meanings
  typedef enum logic [0:0] {
    CMP_BIN = 1'h0,
    CMP_LIST = 1'h1
  } cmp_mode_t;

  // sweep sequencer states, gray along idle -> measure -> compare
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_MEAS = 2'h1,
    ST_CMP = 2'h3
  } sweep_state_t;

  // one measured point with its judgments
  typedef struct packed {
    logic [3:0] index;
    logic last;
    logic point_fail;
    logic prim_above;
    logic prim_below;
    logic sec_reject;
  } point_result_t;

  // handler pin group, active low
  typedef struct packed {
    logic [8:0] point_fail_line_n;
    logic out_line_n;
    logic any_fail_n;
    logic primary_above_limit_n;
    logic primary_below_limit_n;
    logic secondary_reject_n;
    logic analog_done_n;
    logic measurement_end_n;
  } handler_pins_t;

  localparam handler_pins_t PINS_RST = '{
    point_fail_line_n: FAIL_LINES_RST,
    out_line_n: LINE_IDLE,
    any_fail_n: LINE_IDLE,
    primary_above_limit_n: LINE_IDLE,
    primary_below_limit_n: LINE_IDLE,
    secondary_reject_n: LINE_IDLE,
    analog_done_n: LINE_IDLE,
    measurement_end_n: LINE_IDLE
  };

endpackage

// ===== hw/list_sweep_handler_outputs.sv
`timescale 1ns/1ns

module list_sweep_handler_outputs #(
  parameter int unsigned POINTS = handler_out_pkg::NUM_POINTS
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic external_trigger_in_i,
  input wire logic external_trigger_in_mode_i,
  input wire logic list_mode_i,
  input wire logic whole_list_sweep_mode_i,
  input wire logic limit_check_en_i,
  input wire logic analog_done_i,
  input wire logic compare_done_i,
  input wire handler_out_pkg::point_result_t result_i,
  output logic meas_start_o,
  output handler_out_pkg::handler_pins_t pins_o
);

  // ----------------------------------------------------------------
  // trigger synchroniser and edge detect
  // ----------------------------------------------------------------
  logic [1:0] trig_sync_ff;
  logic trig_prev_ff;
  wire logic trig_rise;

  // two stages before anything reads the pin
  // the edge flop resets low like the idle pin, so no false edge
  // follows reset; only the second stage feeds any logic
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_sync_ff <= handler_out_pkg::SYNC_RST;
      trig_prev_ff <= 1'b0;
    end else begin
      trig_sync_ff <= {trig_sync_ff[0], external_trigger_in_i};
      trig_prev_ff <= trig_sync_ff[1];
    end
  end

  assign trig_rise = trig_sync_ff[1] & ~trig_prev_ff;
  assign meas_start_o = external_trigger_in_mode_i & trig_rise;

  // ----------------------------------------------------------------
  // sweep sequencer
  // ----------------------------------------------------------------
  handler_out_pkg::sweep_state_t state_ff;
  handler_out_pkg::sweep_state_t nxt_state;
  wire logic step_mode;
  wire logic point_end;
  wire logic list_end;
  wire logic pulse_done;
  wire logic pulse_end;
  wire logic sweep_start;

  assign step_mode = ~whole_list_sweep_mode_i;
  assign point_end = compare_done_i;
  assign list_end = compare_done_i & result_i.last;
  // a sweep opens whenever the sequencer leaves idle
  assign sweep_start = (state_ff == handler_out_pkg::ST_IDLE) && (nxt_state != handler_out_pkg::ST_IDLE);

  // measure while analog busy, compare until the result arrives
  // with the internal trigger the first analog-done already ends the
  // first measurement, so the sequencer goes straight to compare;
  // waiting in measure for another analog-done would swallow the
  // first compare and keep the accumulator from clearing next list
  // a bin comparison ends after one point, a list after its last
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      handler_out_pkg::ST_IDLE: begin
        if (meas_start_o) begin
          nxt_state = handler_out_pkg::ST_MEAS;
        end else if (!external_trigger_in_mode_i && analog_done_i) begin
          nxt_state = handler_out_pkg::ST_CMP;
        end
      end
      handler_out_pkg::ST_MEAS: begin
        if (analog_done_i) begin
          nxt_state = handler_out_pkg::ST_CMP;
        end
      end
      handler_out_pkg::ST_CMP: begin
        if (list_end || (point_end && !list_mode_i)) begin
          nxt_state = handler_out_pkg::ST_IDLE;
        end else if (point_end) begin
          nxt_state = handler_out_pkg::ST_MEAS;
        end
      end
      default: nxt_state = handler_out_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= handler_out_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // strobe timing
  // ----------------------------------------------------------------
  // list mode: per point in step mode, only on the last point otherwise
  // bin comparison strobes every point, whatever the sweep mode
  assign pulse_done = analog_done_i & (!list_mode_i | step_mode | result_i.last);
  assign pulse_end = list_mode_i ? (step_mode ? point_end : list_end) : point_end;

  // ----------------------------------------------------------------
  // per-point failure accumulation
  // ----------------------------------------------------------------
  logic [POINTS:0] fail_acc_ff;
  logic [POINTS:0] nxt_fail_acc;
  wire logic [POINTS:0] point_bit;

  // one-hot slot for point 1..9, extra slot above that
  // an index of zero or beyond the point count lands on the extra line
  function automatic logic [POINTS:0] slot_of(input logic [3:0] idx);
    logic [POINTS:0] s;
    s = '0;
    if (idx >= 4'h1 && 32'(idx) <= POINTS) begin
      s[idx - 4'h1] = 1'b1;
    end else begin
      s[POINTS] = 1'b1;
    end
    return s;
  endfunction

  assign point_bit = result_i.point_fail ? slot_of(result_i.index) : '0;

  // clear at a new sweep, collect each compared point
  // a clear and a compare in one cycle keep the new point, since
  // the collect is applied after the clear
  always_comb begin
    nxt_fail_acc = fail_acc_ff;
    if (sweep_start) begin
      nxt_fail_acc = '0;
    end
    if (compare_done_i) begin
      nxt_fail_acc = nxt_fail_acc | point_bit;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fail_acc_ff <= '0;
    end else begin
      fail_acc_ff <= nxt_fail_acc;
    end
  end

  // ----------------------------------------------------------------
  // pin assembly, all lines active low
  // ----------------------------------------------------------------
  handler_out_pkg::handler_pins_t pins_ff;
  handler_out_pkg::handler_pins_t nxt_pins;
  wire logic cmp_update;
  wire logic [POINTS:0] list_lines;

  assign cmp_update = pulse_end & limit_check_en_i;
  assign list_lines = nxt_fail_acc;

  // lines read the accumulator's next value so the final point's
  // failure reaches the pins on the same edge as the end strobe;
  // strobes are rebuilt every cycle and stay low for as long as their source is high,
  // result lines hold until the next update or until check goes off
  always_comb begin
    nxt_pins = pins_ff;
    nxt_pins.analog_done_n = ~pulse_done;
    nxt_pins.measurement_end_n = ~pulse_end;
    if (!limit_check_en_i) begin
      nxt_pins.point_fail_line_n = handler_out_pkg::FAIL_LINES_RST;
      nxt_pins.out_line_n = handler_out_pkg::LINE_IDLE;
      nxt_pins.any_fail_n = handler_out_pkg::LINE_IDLE;
      nxt_pins.primary_above_limit_n = handler_out_pkg::LINE_IDLE;
      nxt_pins.primary_below_limit_n = handler_out_pkg::LINE_IDLE;
      nxt_pins.secondary_reject_n = handler_out_pkg::LINE_IDLE;
    end else if (cmp_update && list_mode_i) begin
      nxt_pins.point_fail_line_n = ~list_lines[8:0];
      nxt_pins.out_line_n = ~list_lines[POINTS];
      nxt_pins.any_fail_n = ~(|list_lines);
      nxt_pins.primary_above_limit_n = handler_out_pkg::LINE_IDLE;
      nxt_pins.primary_below_limit_n = handler_out_pkg::LINE_IDLE;
      nxt_pins.secondary_reject_n = handler_out_pkg::LINE_IDLE;
    end else if (cmp_update) begin
      nxt_pins.point_fail_line_n = handler_out_pkg::FAIL_LINES_RST;
      nxt_pins.out_line_n = handler_out_pkg::LINE_IDLE;
      nxt_pins.any_fail_n = handler_out_pkg::LINE_IDLE;
      nxt_pins.primary_above_limit_n = ~result_i.prim_above;
      nxt_pins.primary_below_limit_n = ~result_i.prim_below;
      nxt_pins.secondary_reject_n = ~result_i.sec_reject;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_ff <= handler_out_pkg::PINS_RST;
    end else begin
      pins_ff <= nxt_pins;
    end
  end

  // pins come straight from flops, so the handler never sees a glitch
  assign pins_o = pins_ff;

endmodule

// ===== testbench/list_sweep_handler_monitor.sv
`timescale 1ns/1ns
module list_sweep_handler_monitor (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic external_trigger_in_i,
  input wire logic external_trigger_in_mode_i,
  input wire logic list_mode_i,
  input wire logic whole_list_sweep_mode_i,
  input wire logic limit_check_en_i,
  input wire logic analog_done_i,
  input wire logic compare_done_i,
  input wire handler_out_pkg::point_result_t result_i,
  input wire logic meas_start_o,
  input wire handler_out_pkg::handler_pins_t pins_o
);
  // ----------------
  // strobe and line checks
  // ----------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // whole-list comparison in force
  wire seq_list = whole_list_sweep_mode_i && list_mode_i;
  a_trig_start: assert property ($rose(external_trigger_in_i) && external_trigger_in_mode_i |-> ##[1:4] meas_start_o)
    else $error("no start after trigger");
  a_step_index: assert property (analog_done_i && !whole_list_sweep_mode_i |=> !pins_o.analog_done_n)
    else $error("no analog done");
  a_seq_index: assert property (analog_done_i && seq_list |=> pins_o.analog_done_n != $past(result_i.last))
    else $error("analog done wrong");
  a_step_end: assert property (compare_done_i && !whole_list_sweep_mode_i |=> !pins_o.measurement_end_n)
    else $error("no end strobe");
  a_seq_end: assert property (compare_done_i && seq_list |=> pins_o.measurement_end_n != $past(result_i.last))
    else $error("end strobe wrong");
  a_lines_hold: assert property ($changed(pins_o[15:2]) && $past(limit_check_en_i) |-> !pins_o.measurement_end_n)
    else $error("lines moved early");
  a_check_off: assert property (!limit_check_en_i |=> &pins_o.point_fail_line_n && pins_o.any_fail_n)
    else $error("lines driven while off");
  a_bin_lines: assert property (!pins_o.measurement_end_n && !$past(list_mode_i) |-> &pins_o.point_fail_line_n)
    else $error("bin lines low in bin mode");
  a_bin_above: assert property (compare_done_i && !list_mode_i && limit_check_en_i && result_i.prim_above
    |=> !pins_o.primary_above_limit_n) else $error("above line not low");
endmodule

bind list_sweep_handler_outputs list_sweep_handler_monitor mon (.mclk_i, .rst_n_i, .external_trigger_in_i,
  .external_trigger_in_mode_i, .list_mode_i, .whole_list_sweep_mode_i, .limit_check_en_i, .analog_done_i, .compare_done_i,
  .result_i, .meas_start_o, .pins_o);

// ===== testbench/handler_model.sv
`timescale 1ns/1ns
module handler_model (
  input wire logic mclk_i,
  input wire handler_out_pkg::handler_pins_t pins_i,
  output handler_out_pkg::handler_pins_t seen_o,
  output int n_index_o,
  output int n_end_o
);
  // ----------------
  // part swap and result capture
  // ----------------
  initial begin
    seen_o = handler_out_pkg::PINS_RST;
    n_index_o = 0;
    n_end_o = 0;
  end
  // swap on analog done, read lines only on end strobe
  always @(posedge mclk_i) begin
    if (!pins_i.analog_done_n) begin
      n_index_o <= n_index_o + 1;
    end
    if (!pins_i.measurement_end_n) begin
      n_end_o <= n_end_o + 1;
      seen_o <= pins_i;
    end
  end
endmodule

// ===== testbench/list_sweep_handler_outputs_test.sv
`timescale 1ns/1ns
module list_sweep_handler_outputs_test;
  // ----------------
  // signals and rows
  // ----------------
  typedef struct {logic w, l; logic [3:0] idx; logic last, fail; logic [2:0] prim; logic [8:0] bins_n;
    logic out_n, any_n; logic [2:0] prim_n; int di, de;} row_t;
  logic mclk_i, rst_n_i, external_trigger_in_i, external_trigger_in_mode_i, list_mode_i, whole_list_sweep_mode_i;
  logic limit_check_en_i, analog_done_i, compare_done_i, meas_start_o, hit;
  handler_out_pkg::point_result_t result_i;
  handler_out_pkg::handler_pins_t pins_o, seen;
  int n_mismatch, checked, n_index, n_end, i0, e0;
  wire logic [2:0] prim_seen = {seen.primary_above_limit_n, seen.primary_below_limit_n, seen.secondary_reject_n};
  row_t rows[8] = '{'{0, 1, 4'h1, 1, 1, 3'h0, 9'h1fe, 1, 0, 3'h7, 1, 1},
    '{0, 1, 4'h9, 1, 1, 3'h0, 9'h0ff, 1, 0, 3'h7, 1, 1}, '{0, 1, 4'h3, 1, 0, 3'h0, 9'h1ff, 1, 1, 3'h7, 1, 1},
    '{0, 1, 4'hc, 1, 1, 3'h0, 9'h1ff, 0, 0, 3'h7, 1, 1}, '{1, 1, 4'h1, 0, 1, 3'h0, 9'h1ff, 0, 0, 3'h7, 0, 0},
    '{1, 1, 4'h2, 1, 0, 3'h0, 9'h1fe, 1, 0, 3'h7, 1, 1}, '{0, 0, 4'h5, 1, 1, 3'h4, 9'h1ff, 1, 1, 3'h3, 1, 1},
    '{0, 0, 4'h6, 1, 0, 3'h3, 9'h1ff, 1, 1, 3'h4, 1, 1}};
  list_sweep_handler_outputs dut (.mclk_i, .rst_n_i, .external_trigger_in_i, .external_trigger_in_mode_i, .list_mode_i,
    .whole_list_sweep_mode_i, .limit_check_en_i, .analog_done_i, .compare_done_i, .result_i, .meas_start_o, .pins_o);
  handler_model peer (.mclk_i, .pins_i(pins_o), .seen_o(seen), .n_index_o(n_index), .n_end_o(n_end));
  // ----------------
  // tasks
  // ----------------
  task automatic cmp_v(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_n(input string what, input int exp, input int got);
    checked++;
    if (got != exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // one point: analog done, then compare done with its result
  task automatic pt(input row_t r);
    @(posedge mclk_i) #2;
    whole_list_sweep_mode_i = r.w;
    list_mode_i = r.l;
    result_i = '{r.idx, r.last, r.fail, r.prim[2], r.prim[1], r.prim[0]};
    analog_done_i = 1;
    @(posedge mclk_i) #2 analog_done_i = 0;
    @(posedge mclk_i) #2 compare_done_i = 1;
    @(posedge mclk_i) #2 compare_done_i = 0;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------
  // clock, watchdog, tests
  // ----------------
  initial begin
    mclk_i = 0;
    forever #10 mclk_i = ~mclk_i;
  end
  initial begin
    #20000 n_mismatch++;
    tally_and_finish();
  end
  initial begin
    {rst_n_i, external_trigger_in_i, external_trigger_in_mode_i, whole_list_sweep_mode_i, analog_done_i, compare_done_i} = '0;
    {list_mode_i, limit_check_en_i} = 2'h3;
    result_i = '0;
    repeat (10) @(posedge mclk_i);
    cmp_v("reset pins", handler_out_pkg::PINS_RST, pins_o);
    #2 rst_n_i = 1;
    $display("reset done");
    foreach (rows[i]) begin
      i0 = n_index;
      e0 = n_end;
      pt(rows[i]);
      cmp_v("bins", rows[i].bins_n, seen.point_fail_line_n);
      cmp_v("out", rows[i].out_n, seen.out_line_n);
      cmp_v("any", rows[i].any_n, seen.any_fail_n);
      cmp_v("prim", rows[i].prim_n, prim_seen);
      cmp_n("index count", rows[i].di, n_index - i0);
      cmp_n("end count", rows[i].de, n_end - e0);
      $display("row %0d done", i);
    end
    #2 rst_n_i = 0;
    @(posedge mclk_i) #2 cmp_v("reset mid", handler_out_pkg::PINS_RST, pins_o);
    rst_n_i = 1;
    $display("mid reset done");
    #2 limit_check_en_i = 0;
    pt(rows[1]);
    cmp_v("bins off", 9'h1ff, pins_o.point_fail_line_n);
    $display("limit off done");
    for (int k = 1; k >= 0; k--) begin
      @(posedge mclk_i) #2 external_trigger_in_mode_i = k[0];
      external_trigger_in_i = 1;
      hit = 0;
      repeat (6) begin
        @(posedge mclk_i) #2;
        if (meas_start_o === 1'b1) hit = 1;
      end
      cmp_v("start", k[0], hit);
      @(posedge mclk_i) #2 external_trigger_in_i = 0;
      repeat (4) @(posedge mclk_i);
    end
    $display("trigger done");
    tally_and_finish();
  end
endmodule
